/* hw/scp_nsr_core.sv */
// Core-clock side: active requantizer settings, transfer crossing, idle detect.
// Assumes shadow bytes are stable while a transfer toggle is in flight.
`timescale 1ns/1ps
`default_nettype none
module scp_nsr_core #(
   parameter logic [5:0] WIDE_LP_MAX = 6'h0F,
   parameter logic [5:0] WIDE_HP_MIN = 6'h30,
   parameter int HIZ_CYC = scp_pkg::HIZ_IDLE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_chip_select_low_n,
   scp_core_if.core cif
);
   import scp_pkg::*;
   localparam int CW = $clog2(HIZ_CYC + 1);
   localparam logic [CW-1:0] HIZ_MAX = CW'(HIZ_CYC);

   logic cs_s1_r, cs_s2_r, rq_s1_r, rq_s2_r, rq_s3_r, ack_r;
   logic [7:0] act_ctrl_r, act_tune_r;
   logic [CW-1:0] hi_cnt_r;
   wire xfer_ev = rq_s2_r ^ rq_s3_r;
   wire [MODE_W-1:0] mode = act_ctrl_r[CTRL_MODE_LSB +: MODE_W];
   wire en = act_ctrl_r[CTRL_EN_BIT];
   wire [TW_W-1:0] tw = act_tune_r[TW_W-1:0];
   wire narrow = en & (mode == MODE_NARROW);
   wire wide = en & (mode == MODE_WIDE);
   wire [BAND_W-1:0] tw_ext = {1'b0, tw};
   wire [CW-1:0] hi_cnt_nxt = (!cs_s2_r) ? '0 : (hi_cnt_r == HIZ_MAX) ? hi_cnt_r : hi_cnt_r + 1'b1;
   scp_shape_t shape_nxt;
   assign shape_nxt = !wide ? SHP_NONE : (tw <= WIDE_LP_MAX) ? SHP_LOW :
      (tw >= WIDE_HP_MIN) ? SHP_HIGH : SHP_BAND;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {cs_s1_r, cs_s2_r, rq_s1_r, rq_s2_r, rq_s3_r, ack_r} <= 6'h3F & 6'h30;
         act_ctrl_r <= CTRL_RST;
         act_tune_r <= TUNE_RST;
         hi_cnt_r <= '0;
      end else if (i_ce) begin
         cs_s1_r <= i_chip_select_low_n;
         cs_s2_r <= cs_s1_r;
         rq_s1_r <= cif.req_tgl;
         rq_s2_r <= rq_s1_r;
         rq_s3_r <= rq_s2_r;
         hi_cnt_r <= hi_cnt_nxt;
         if (xfer_ev) begin
            act_ctrl_r <= cif.sh_ctrl;
            act_tune_r <= cif.sh_tune;
            ack_r <= ~ack_r;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cif.nsr_en <= 1'b0;
         cif.nsr_mode <= '0;
         cif.tune <= '0;
         cif.tune_bad <= 1'b0;
         cif.band_lo <= '0;
         cif.band_ctr <= '0;
         cif.band_hi <= '0;
         cif.shape <= SHP_NONE;
         cif.gain <= GAIN_UNITY;
         cif.sec_en <= 1'b0;
      end else if (i_ce) begin
         cif.nsr_en <= en;
         cif.nsr_mode <= mode;
         cif.tune <= tw;
         cif.tune_bad <= narrow & (tw > TW_NARROW_MAX);
         cif.band_lo <= narrow ? tw_ext : '0;
         cif.band_ctr <= narrow ? tw_ext + STEP_CTR : '0;
         cif.band_hi <= narrow ? tw_ext + STEP_HI : '0;
         cif.shape <= shape_nxt;
         cif.gain <= en ? GAIN_NSR : GAIN_UNITY;
         cif.sec_en <= (hi_cnt_r == HIZ_MAX);
      end
   end

   assign cif.ack_tgl = ack_r;
endmodule // scp_nsr_core
`default_nettype wire

/* hw/scp_serial_port.sv */
// Three-wire serial configuration port with requantizer register bank.
// Assumes the host idles the serial clock low and changes data on falling edges.
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port #(
   parameter logic [5:0] WIDE_LP_MAX = 6'h0F,
   parameter logic [5:0] WIDE_HP_MIN = 6'h30,
   parameter int HIZ_CYC = scp_pkg::HIZ_IDLE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_sclk,
   input wire logic i_chip_select_low_n,
   input wire logic i_sdio,
   output logic o_sdio,
   output logic o_sdio_oe,
   output logic o_lsb_first,
   output logic o_secondary_en,
   output logic o_nsr_enable,
   output logic [scp_pkg::MODE_W-1:0] o_nsr_mode,
   output logic [scp_pkg::TW_W-1:0] o_band_tuning_value,
   output logic o_tuning_invalid,
   output logic [scp_pkg::BAND_W-1:0] o_band_lo,
   output logic [scp_pkg::BAND_W-1:0] o_band_ctr,
   output logic [scp_pkg::BAND_W-1:0] o_band_hi,
   output logic [1:0] o_wide_shape,
   output logic [scp_pkg::GAIN_W-1:0] o_gain_q15
);
   import scp_pkg::*;

   // Readback of the register space
   function automatic logic [7:0] rd_mux(
      input logic [ADDR_W-1:0] a,
      input logic lsb,
      input logic [7:0] ctrl,
      input logic [7:0] tune,
      input logic pend
   );
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_PORT_CFG: begin
            v = PORT_CFG_RST;
            v[CFG_LSB_HI] = lsb;
            v[CFG_LSB_LO] = lsb;
         end
         ADDR_CTRL: v = ctrl;
         ADDR_TUNE: v = tune;
         ADDR_XFER: v = {7'h00, pend};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   scp_core_if cif ();

   scp_nsr_core #(
      .WIDE_LP_MAX(WIDE_LP_MAX),
      .WIDE_HP_MIN(WIDE_HP_MIN),
      .HIZ_CYC(HIZ_CYC)
   ) u_core (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_chip_select_low_n(i_chip_select_low_n),
      .cif(cif.core)
   );

   // Serial-clock state
   scp_state_t st_r;
   logic [3:0] cnt_r;
   logic [15:0] sh_r;
   logic rd_r;
   logic [1:0] left_r;
   logic strm_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] rd_byte_r;
   logic lsb_r;
   logic [7:0] ctrl_r;
   logic [7:0] tune_r;
   logic req_r;
   logic ack_s1_r;
   logic ack_s2_r;
   logic cs_hi_r;
   logic sdio_r;
   logic oe_r;

   // Chip select level and pause detection
   wire cs_lo = ~i_chip_select_low_n;
   wire cs_hi_set = i_chip_select_low_n | ~i_rst_n;
   wire oe_clr_n = i_rst_n & cs_lo;

   // Raise mid-byte or in streaming ends the frame; at a byte edge it pauses
   wire abort = cs_hi_r & ((cnt_r != 4'h0) | ((st_r == ST_DATA) & strm_r));
   wire in_instr = abort | (st_r == ST_INSTR);
   wire [3:0] cnt_eff = abort ? 4'h0 : cnt_r;

   // Shift path
   wire [15:0] sh_in = {sh_r[14:0], i_sdio};
   wire [15:0] ins_w = lsb_r ? scp_rev16(sh_in) : sh_in;
   wire [7:0] wr_b = lsb_r ? scp_rev8(sh_in[7:0]) : sh_in[7:0];
   wire last_bit = in_instr ? (cnt_eff == 4'(INS_LAST)) : (cnt_eff == 4'(BYTE_LAST));
   wire ins_done = in_instr & last_bit;
   wire byte_done = ~in_instr & last_bit;

   // Instruction fields
   wire ins_rd = ins_w[INS_RW];
   wire [1:0] ins_len = ins_w[INS_LEN_LO +: 2];
   wire [ADDR_W-1:0] ins_addr = ins_w[ADDR_W-1:0];
   wire frame_end = byte_done & ~strm_r & (left_r == 2'h0);
   wire [ADDR_W-1:0] addr_inc = addr_r + 1'b1;

   // Register decode
   wire wr_en = byte_done & ~rd_r;
   wire hit_cfg = wr_en & (addr_r == ADDR_PORT_CFG);
   wire hit_ctrl = wr_en & (addr_r == ADDR_CTRL);
   wire hit_tune = wr_en & (addr_r == ADDR_TUNE);
   wire hit_xfer = wr_en & (addr_r == ADDR_XFER);
   wire srst = hit_cfg & (wr_b[CFG_SRST_HI] | wr_b[CFG_SRST_LO]);
   wire pend = req_r ^ ack_s2_r;

   // Next values
   scp_state_t st_nxt;
   assign st_nxt = ins_done ? ST_DATA : (frame_end ? ST_INSTR : (in_instr ? ST_INSTR : ST_DATA));
   wire [3:0] cnt_nxt = last_bit ? 4'h0 : cnt_eff + 4'h1;
   wire rd_nxt = ins_done ? ins_rd : rd_r;
   wire [1:0] left_nxt = ins_done ? ins_len : (byte_done ? left_r - 2'h1 : left_r);
   wire strm_nxt = ins_done ? (ins_len == LEN_STREAM) : strm_r;
   wire [ADDR_W-1:0] addr_nxt = ins_done ? ins_addr : (byte_done ? addr_inc : addr_r);
   wire [7:0] rd_byte_nxt = ins_done ? rd_mux(ins_addr, lsb_r, ctrl_r, tune_r, pend) :
      (byte_done ? rd_mux(addr_inc, lsb_r, ctrl_r, tune_r, pend) : rd_byte_r);
   wire lsb_nxt = srst ? 1'b0 : (hit_cfg ? (wr_b[CFG_LSB_HI] | wr_b[CFG_LSB_LO]) : lsb_r);
   wire [7:0] ctrl_nxt = srst ? CTRL_RST : (hit_ctrl ? (wr_b & CTRL_MASK) : ctrl_r);
   wire [7:0] tune_nxt = srst ? TUNE_RST : (hit_tune ? (wr_b & TUNE_MASK) : tune_r);
   wire req_nxt = req_r ^ (hit_xfer & (wr_b == XFER_CMD) & ~pend);

   // Output side
   wire drive = (st_r == ST_DATA) & rd_r;
   wire [2:0] bit_idx = lsb_r ? cnt_r[2:0] : 3'h7 - cnt_r[2:0];
   wire tx_bit = rd_byte_r[bit_idx];

   // Pause flag, set while chip select is high
   always_ff @(posedge i_sclk or posedge cs_hi_set) begin
      if (cs_hi_set) begin
         cs_hi_r <= 1'b1;
      end else begin
         cs_hi_r <= 1'b0;
      end
   end

   // Transfer acknowledge back from the core domain
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= cif.ack_tgl;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Frame engine, rising serial clock
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_r <= ST_INSTR;
         cnt_r <= 4'h0;
         sh_r <= 16'h0000;
         rd_r <= 1'b0;
         left_r <= 2'h0;
         strm_r <= 1'b0;
         addr_r <= '0;
         rd_byte_r <= 8'h00;
      end else if (cs_lo) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_in;
         rd_r <= rd_nxt;
         left_r <= left_nxt;
         strm_r <= strm_nxt;
         addr_r <= addr_nxt;
         rd_byte_r <= rd_byte_nxt;
      end
   end

   // Shadow registers, rising serial clock
   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lsb_r <= 1'b0;
         ctrl_r <= CTRL_RST;
         tune_r <= TUNE_RST;
         req_r <= 1'b0;
      end else if (cs_lo) begin
         lsb_r <= lsb_nxt;
         ctrl_r <= ctrl_nxt;
         tune_r <= tune_nxt;
         req_r <= req_nxt;
      end
   end

   // Data pin driver, falling serial clock; floats as soon as select rises
   always_ff @(negedge i_sclk or negedge oe_clr_n) begin
      if (!oe_clr_n) begin
         oe_r <= 1'b0;
         sdio_r <= 1'b0;
      end else begin
         oe_r <= drive;
         sdio_r <= drive & tx_bit;
      end
   end

   assign cif.req_tgl = req_r;
   assign cif.sh_ctrl = ctrl_r;
   assign cif.sh_tune = tune_r;

   assign o_sdio = sdio_r;
   assign o_sdio_oe = oe_r;
   assign o_lsb_first = lsb_r;
   assign o_secondary_en = cif.sec_en;
   assign o_nsr_enable = cif.nsr_en;
   assign o_nsr_mode = cif.nsr_mode;
   assign o_band_tuning_value = cif.tune;
   assign o_tuning_invalid = cif.tune_bad;
   assign o_band_lo = cif.band_lo;
   assign o_band_ctr = cif.band_ctr;
   assign o_band_hi = cif.band_hi;
   assign o_wide_shape = cif.shape;
   assign o_gain_q15 = cif.gain;
endmodule // scp_serial_port
`default_nettype wire

/* include/scp_core_if.sv */
// Carrier between the serial engine and the core-clock register bank.
// Engine side runs on the serial clock, core side on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface scp_core_if;
   import scp_pkg::*;
   logic req_tgl;
   logic ack_tgl;
   logic [7:0] sh_ctrl;
   logic [7:0] sh_tune;
   logic nsr_en;
   logic [MODE_W-1:0] nsr_mode;
   logic [TW_W-1:0] tune;
   logic tune_bad;
   logic [BAND_W-1:0] band_lo;
   logic [BAND_W-1:0] band_ctr;
   logic [BAND_W-1:0] band_hi;
   scp_shape_t shape;
   logic [GAIN_W-1:0] gain;
   logic sec_en;
   modport eng (output req_tgl, sh_ctrl, sh_tune, input ack_tgl, nsr_en, nsr_mode, tune,
      tune_bad, band_lo, band_ctr, band_hi, shape, gain, sec_en);
   modport core (input req_tgl, sh_ctrl, sh_tune, output ack_tgl, nsr_en, nsr_mode, tune,
      tune_bad, band_lo, band_ctr, band_hi, shape, gain, sec_en);
endinterface // scp_core_if
`default_nettype wire

/* include/scp_pkg.sv */
// Constants, types and helper functions for the serial config port.
// Assumes one core clock domain and one serial-clock domain from the host.
// Function
// - Each frame opens with a sixteen-bit instruction before any data byte.
// - Two length bits in the instruction set how many data bytes follow.
// - Data after the instruction moves only as whole eight-bit bytes.
// - Leading instruction bit picks read or write.
// - On a read the device turns the data pin to drive after the instruction.
// - Data pin is input during writes, driven only during readback.
// - Chip select falling then a rising serial clock aligns the frame.
// - Chip select held low streams consecutive bytes indefinitely.
// - Chip select high between bytes pauses; low again resumes the frame (streaming frames end instead).
// - Chip select held high floats the port and enables secondary pin functions.
// - Chip select is active low; cycles proceed only while it is low.
// - Host supplies the serial clock that times all shifting; clock and select are inputs.
// - Bits go MSB first after reset; port config register can select LSB first.
// - Control bits 3..1 equal 000 select the narrow 22 percent passband mode.
// - Narrow mode tuning field bits 5..0 has 57 valid values only.
// - Narrow band edges: low 0.005*fs*tuning, centre +0.11*fs, upper +0.22*fs.
// - Wide mode tuning field places low-pass, band-pass or high-pass response.
// - With requantizer enabled, output is attenuated by an extra 0.6 dB.
// - Shadowed registers take effect on writing 0x01 to transfer register; bit self-clears.
`default_nettype none
package scp_pkg;
   localparam int ADDR_W = 13;
   localparam int TW_W = 6;
   localparam int BAND_W = 7;
   localparam int MODE_W = 3;
   localparam int GAIN_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_PORT_CFG = 13'h0000;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 13'h003C;
   localparam logic [ADDR_W-1:0] ADDR_TUNE = 13'h003E;
   localparam logic [ADDR_W-1:0] ADDR_XFER = 13'h00FF;
   localparam logic [7:0] PORT_CFG_RST = 8'h18;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] TUNE_RST = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h0F;
   localparam logic [7:0] TUNE_MASK = 8'h3F;
   localparam logic [7:0] XFER_CMD = 8'h01;
   localparam int CFG_LSB_HI = 6;
   localparam int CFG_LSB_LO = 1;
   localparam int CFG_SRST_HI = 5;
   localparam int CFG_SRST_LO = 2;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam logic [MODE_W-1:0] MODE_NARROW = 3'h0;
   localparam logic [MODE_W-1:0] MODE_WIDE = 3'h1;
   localparam logic [TW_W-1:0] TW_NARROW_MAX = 6'h38;
   localparam logic [BAND_W-1:0] STEP_CTR = 7'h16;
   localparam logic [BAND_W-1:0] STEP_HI = 7'h2C;
   localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h7FFF;
   localparam logic [GAIN_W-1:0] GAIN_NSR = 16'h7775;
   localparam int INS_RW = 15;
   localparam int INS_LEN_LO = 13;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam int INS_LAST = 15;
   localparam int BYTE_LAST = 7;
   localparam int CORE_CLK_NS = 100;
   localparam int HIZ_IDLE_NS = 10000;
   localparam int HIZ_IDLE_CYC = (HIZ_IDLE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int HIZ_CNT_W = $clog2(HIZ_IDLE_CYC + 1);

   typedef enum logic {ST_INSTR, ST_DATA} scp_state_t;
   typedef enum logic [1:0] {SHP_NONE, SHP_LOW, SHP_BAND, SHP_HIGH} scp_shape_t;

   function automatic logic [7:0] scp_rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction

   function automatic logic [15:0] scp_rev16(input logic [15:0] v);
      return {scp_rev8(v[7:0]), scp_rev8(v[15:8])};
   endfunction
endpackage
`default_nettype wire

/* tb/scp_host_model.sv */
// Serial host model: drives clock, select and data pin, samples readback.
// Clock runs only inside frames; data changes while the clock is low.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_d,
   output logic o_oe,
   input wire logic i_line
);
   logic lsb;
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_d = 1'b0;
      o_oe = 1'b0;
      lsb = 1'b0;
   end
   task automatic bit_cyc(input logic d, input logic drv, output logic q);
      o_oe = drv;
      o_d = drv ? d : ~o_d;
      #24 q = i_line;
      o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
   endtask
   task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] a,
      input int n, input logic pause, input logic [23:0] wd, output logic [23:0] rq);
      logic [15:0] ins;
      logic q;
      int p;
      ins = {rd, len, a};
      rq = '0;
      o_cs_n = 1'b0;
      #24;
      for (int i = 0; i < 16; i++) begin
         bit_cyc(ins[lsb ? i : 15 - i], 1'b1, q);
      end
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 8; i++) begin
            p = (2 - k) * 8 + (lsb ? i : 7 - i);
            bit_cyc(wd[p], !rd, q);
            rq[p] = q;
         end
         if (pause && k < n - 1) begin
            o_oe = 1'b0;
            #24 o_cs_n = 1'b1;
            #300 o_cs_n = 1'b0;
            #24;
         end
      end
      o_oe = 1'b0;
      #24 o_cs_n = 1'b1;
      #100;
   endtask
endmodule // scp_host_model
`default_nettype wire

/* tb/scp_serial_port_checker.sv */
// Checker for the serial port top: data pin direction, idle float, requantizer outputs.
// Bound to every scp_serial_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port_checker #(
   parameter logic [5:0] WIDE_LP_MAX = 6'h0F,
   parameter logic [5:0] WIDE_HP_MIN = 6'h30,
   parameter int HIZ_CYC = scp_pkg::HIZ_IDLE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_sclk,
   input wire logic i_chip_select_low_n,
   input wire logic i_sdio,
   input wire logic o_sdio,
   input wire logic o_sdio_oe,
   input wire logic o_lsb_first,
   input wire logic o_secondary_en,
   input wire logic o_nsr_enable,
   input wire logic [scp_pkg::MODE_W-1:0] o_nsr_mode,
   input wire logic [scp_pkg::TW_W-1:0] o_band_tuning_value,
   input wire logic o_tuning_invalid,
   input wire logic [scp_pkg::BAND_W-1:0] o_band_lo,
   input wire logic [scp_pkg::BAND_W-1:0] o_band_ctr,
   input wire logic [scp_pkg::BAND_W-1:0] o_band_hi,
   input wire logic [1:0] o_wide_shape,
   input wire logic [scp_pkg::GAIN_W-1:0] o_gain_q15
);
   import scp_pkg::*;
   logic [15:0] hi_cnt;
   logic [15:0] bit_cnt;
   logic nar;
   logic [1:0] shp;
   assign nar = o_nsr_enable && o_nsr_mode == MODE_NARROW;
   assign shp = (o_band_tuning_value <= WIDE_LP_MAX) ? 2'h1 :
      (o_band_tuning_value >= WIDE_HP_MIN) ? 2'h3 : 2'h2;
   // Core cycles with the select high
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) hi_cnt <= '0;
      else if (i_ce) hi_cnt <= i_chip_select_low_n ? hi_cnt + {15'h0, ~&hi_cnt} : 16'h0;
   end
   // Rising serial edges since the select fell
   always_ff @(posedge i_sclk or posedge i_chip_select_low_n or negedge i_rst_n) begin
      if (!i_rst_n) bit_cnt <= '0;
      else if (i_chip_select_low_n) bit_cnt <= '0;
      else bit_cnt <= bit_cnt + 16'h1;
   end
   oe_idle_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_chip_select_low_n |-> !o_sdio_oe) else $error("pin driven while deselected");
   oe_start_a: assert property (@(negedge i_sclk) disable iff (!i_rst_n || i_chip_select_low_n)
      $rose(o_sdio_oe) |-> bit_cnt[2:0] == 3'h1 && bit_cnt >= 16'h0011)
      else $error("pin turned at wrong bit");
   oe_hold_a: assert property (@(negedge i_sclk) disable iff (!i_rst_n || i_chip_select_low_n)
      o_sdio_oe && bit_cnt[2:0] != 3'h0 |=> o_sdio_oe) else $error("pin released mid byte");
   sec_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      !i_chip_select_low_n [*5] |-> !o_secondary_en) else $error("float while selected");
   sec_on_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      hi_cnt >= HIZ_CYC + 4 |-> o_secondary_en) else $error("no float when idle");
   sec_early_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || !i_ce)
      $rose(o_secondary_en) |-> hi_cnt >= HIZ_CYC - 1) else $error("float too early");
   gain_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_gain_q15 == (o_nsr_enable ? GAIN_NSR : GAIN_UNITY)) else $error("gain wrong");
   band_edges_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      nar ? (o_band_lo == {1'b0, o_band_tuning_value} && o_band_ctr == o_band_lo + STEP_CTR
      && o_band_hi == o_band_lo + STEP_HI) : (o_band_lo | o_band_ctr | o_band_hi) == 7'h00)
      else $error("band edges wrong");
   tune_bad_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_tuning_invalid == (nar && o_band_tuning_value > TW_NARROW_MAX))
      else $error("tuning flag wrong");
   wide_shape_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_wide_shape == ((o_nsr_enable && o_nsr_mode == MODE_WIDE) ? shp : 2'h0))
      else $error("shape wrong");
   narrow_c: cover property (@(posedge i_core_clk) nar && o_band_tuning_value == 6'h38);
   high_c: cover property (@(posedge i_core_clk) o_wide_shape == 2'h3);
   read_c: cover property (@(negedge i_sclk) $rose(o_sdio_oe));
endmodule // scp_serial_port_checker
bind scp_serial_port scp_serial_port_checker #(.WIDE_LP_MAX(WIDE_LP_MAX),
   .WIDE_HP_MIN(WIDE_HP_MIN), .HIZ_CYC(HIZ_CYC)) chk_u (.*);
`default_nettype wire

/* tb/scp_serial_port_tb_top.sv */
// Bench for the serial port: host frames, register readback, requantizer outputs.
// Core clock 100 ns; host clock 48 ns inside frames; idle float count cut to 5.
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port_tb_top;
   import scp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tgl = 1'b0;
   logic ce = 1'b1;
   logic sclk, cs_n, h_d, h_oe, line, sdo, sdo_oe, lsbf, sec, en, inv;
   logic [MODE_W-1:0] mode;
   logic [TW_W-1:0] tw;
   logic [BAND_W-1:0] lo, ctr, hi;
   logic [1:0] shp;
   logic [GAIN_W-1:0] gain;
   logic [23:0] rq;
   logic [49:0] obs;
   logic [15:0] tab [7] = '{16'h0139, 16'h030F, 16'h0310, 16'h0330, 16'h0520, 16'h0005,
      16'h0100};
   int n_mismatch = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   // Undriven line wanders
   always @(negedge clk) tgl <= ~tgl;
   assign line = sdo_oe ? sdo : (h_oe ? h_d : tgl);
   assign obs = {en, mode, tw, inv, lo, ctr, hi, shp, gain};
   scp_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_d(h_d), .o_oe(h_oe), .i_line(line));
   scp_serial_port #(.HIZ_CYC(5)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_sclk(sclk), .i_chip_select_low_n(cs_n), .i_sdio(line), .o_sdio(sdo),
      .o_sdio_oe(sdo_oe), .o_lsb_first(lsbf), .o_secondary_en(sec), .o_nsr_enable(en),
      .o_nsr_mode(mode), .o_band_tuning_value(tw), .o_tuning_invalid(inv), .o_band_lo(lo),
      .o_band_ctr(ctr), .o_band_hi(hi), .o_wide_shape(shp), .o_gain_q15(gain));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host_u.frame(1'b0, 2'h0, a, 1, 1'b0, {d, 16'h0}, rq);
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
      host_u.frame(1'b1, 2'h0, a, 1, 1'b0, 24'h0, rq);
      chk(rq[23:16], e, "readback");
   endtask
   task automatic apply();
      wr(ADDR_XFER, XFER_CMD);
      repeat (8) @(negedge clk);
   endtask
   function automatic logic [49:0] want(input logic [7:0] c, input logic [7:0] t);
      logic nar;
      logic [6:0] b;
      logic [1:0] s;
      nar = c[0] && c[3:1] == 3'h0;
      b = nar ? {1'b0, t[5:0]} : 7'h00;
      s = (!c[0] || c[3:1] != 3'h1) ? 2'h0 : (t[5:0] <= 6'h0F) ? 2'h1 : (t[5:0] >= 6'h30) ? 2'h3 : 2'h2;
      return {c[0], c[3:1], t[5:0], nar && t[5:0] > 6'h38, b, nar ? b + 7'h16 : 7'h00,
         nar ? b + 7'h2C : 7'h00, s, c[0] ? 16'h7775 : 16'h7FFF};
   endfunction
   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge sclk) if (sdo_oe && h_oe) chk(1'b1, 1'b0, "pin contention");
   initial begin
      #500000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk({lsbf, en, gain}, {2'b00, GAIN_UNITY}, "reset outputs");
      rd_chk(ADDR_PORT_CFG, PORT_CFG_RST);
      rd_chk(ADDR_CTRL, CTRL_RST);
      repeat (12) @(negedge clk);
      chk(sec, 1'b1, "idle float");
      $display("test reset done");
      host_u.frame(1'b0, 2'h2, ADDR_CTRL, 3, 1'b0, 24'h01A538, rq);
      repeat (12) @(negedge clk);
      chk({en, gain}, {1'b0, GAIN_UNITY}, "shadow held");
      apply();
      chk(obs, want(8'h01, 8'h38), "narrow top");
      host_u.frame(1'b1, 2'h3, ADDR_CTRL, 3, 1'b0, 24'h0, rq);
      chk(rq, 24'h010038, "stream read");
      $display("test shadow done");
      foreach (tab[j]) begin
         host_u.frame(1'b0, 2'h2, ADDR_CTRL, 3, 1'b1, {tab[j][15:8], 8'h00, tab[j][7:0]}, rq);
         apply();
         chk(obs, want(tab[j][15:8], tab[j][7:0]), "mode table");
      end
      $display("test modes done");
      ce = 1'b0;
      wr(ADDR_CTRL, 8'h03);
      apply();
      chk(obs, want(8'h01, 8'h00), "frozen outputs");
      rd_chk(ADDR_XFER, XFER_CMD);
      @(negedge clk);
      ce = 1'b1;
      repeat (8) @(negedge clk);
      chk(obs, want(8'h03, 8'h00), "thawed outputs");
      rd_chk(ADDR_XFER, 8'h00);
      $display("test freeze done");
      wr(ADDR_PORT_CFG, 8'h42);
      chk(lsbf, 1'b1, "lsb first");
      host_u.lsb = 1'b1;
      wr(ADDR_TUNE, 8'h2B);
      rd_chk(ADDR_TUNE, 8'h2B);
      rd_chk(ADDR_CTRL, 8'h03);
      wr(ADDR_PORT_CFG, 8'h24);
      host_u.lsb = 1'b0;
      chk(lsbf, 1'b0, "soft reset order");
      rd_chk(ADDR_TUNE, TUNE_RST);
      $display("test order done");
      stop_test();
   end
endmodule // scp_serial_port_tb_top
`default_nettype wire
